// ### qdc_pkg.sv
// ==========================================================================
// shared constants and carriers for the quad converter control bank
package qdc_pkg;

   // ======================================================================
   // serial frame layout
   localparam int FRAME_BITS = 24;
   localparam int FRAME_BITS_CHECKED = 32;
   localparam int CHECK_BITS = 8;
   localparam int POS_RW = 23;
   localparam int POS_DEV_HI = 22;
   localparam int POS_GROUP_HI = 20;
   localparam int POS_CHAN_HI = 17;
   localparam int POS_TARGET_HI = 15;
   localparam logic [2:0] GROUP_CONTROL = 3'h7;

   typedef enum logic [2:0] {
      QDC_TGT_SLEW = 3'b000,
      QDC_TGT_GLOBAL = 3'b001,
      QDC_TGT_CHANNEL = 3'b010,
      QDC_TGT_BOOST = 3'b011,
      QDC_TGT_SOFT = 3'b100
   } qdc_target_e;

   // ======================================================================
   // field positions inside the 16-bit data part
   localparam int GC_INVERT = 12;
   localparam int GC_STATUS = 11;
   localparam int GC_WD_ON = 10;
   localparam int GC_WD_SEL_LO = 8;
   localparam int GC_SHORT = 6;
   localparam int GC_OUT_ALL = 5;
   localparam int GC_BOOST_ALL = 4;
   localparam int CC_CORE = 8;
   localparam int CC_CLEAR = 7;
   localparam int CC_OUT = 6;
   localparam int CC_SENSE_RESISTOR_SELECT = 5;
   localparam int CC_BOOST = 4;
   localparam int CC_OVR = 3;
   localparam int CC_RANGE_LO = 0;
   localparam int CC_RANGE_CURRENT = 2;
   localparam int SW_TOGGLE = 12;
   localparam int SW_CODE_BITS = 12;
   localparam logic [11:0] SW_RESET_CODE = 12'h555;
   localparam logic [11:0] SW_KICK_CODE = 12'h195;
   localparam int BC_COMP = 6;
   localparam int BC_PHASE_LO = 4;
   localparam int BC_FREQ_LO = 2;
   localparam int BC_VMAX_LO = 0;
   localparam int SLEW_BITS = 13;
   localparam int ST_TOGGLE = 11;

   // ======================================================================
   // register carriers
   typedef struct packed {
      logic idle_output_level_invert;
      logic status_on_write_enable;
      logic watchdog_on;
      logic [1:0] watchdog_period_sel;
      logic short_limit_select;
      logic global_output_on;
      logic global_boost_power_up;
   } qdc_glob_s;

   typedef struct packed {
      logic core_power_up;
      logic clear_participation;
      logic channel_output_on;
      logic sense_resistor_select;
      logic channel_boost_power_up;
      logic overrange_on;
      logic [2:0] range_code;
   } qdc_chan_s;

   typedef struct packed {
      logic boost_compensation_select;
      logic [1:0] boost_phase_select;
      logic [1:0] boost_frequency_select;
      logic [1:0] boost_voltage_limit;
   } qdc_boost_s;

   // ======================================================================
   // reset values
   localparam qdc_glob_s GLOB_RESET = '0;
   localparam qdc_chan_s CHAN_RESET = '0;
   localparam qdc_boost_s BOOST_RESET = '{1'b0, 2'h0, 2'h1, 2'h0};
   localparam logic [12:0] SLEW_RESET = 13'h0000;

   // ======================================================================
   // watchdog timing, periods in milliseconds
   localparam int CLK_MHZ = 200;
   localparam int WD_TIME_0_MS = 5;
   localparam int WD_TIME_1_MS = 10;
   localparam int WD_TIME_2_MS = 100;
   localparam int WD_TIME_3_MS = 200;
   localparam int CYCLES_PER_MS = CLK_MHZ * 1000;

endpackage

// ### qdc_bank.sv
`timescale 1ns/100ps

module qdc_bank
   import qdc_pkg::*;
#(
   parameter int unsigned WD_UNIT_CYCLES = CYCLES_PER_MS
) (
   // system
   input wire logic clock,
   input wire logic rst_b,
   // serial link
   input wire logic link_clock,
   input wire logic sync_b,
   input wire logic serial_in,
   input wire logic frame_check,
   output logic status_out,
   // pins
   input wire logic [1:0] device_select_pins,
   input wire logic idle_level_pin,
   // configuration outputs
   output qdc_glob_s glob_cfg,
   output qdc_chan_s [3:0] chan_cfg,
   output qdc_boost_s boost_cfg,
   output logic [3:0][12:0] slew_cfg,
   // derived state
   output logic [3:0] output_active,
   output logic [3:0] boost_active,
   output logic [3:0] overrange_active,
   output logic idle_level,
   output logic [15:0] status_word,
   output logic alert
);

   // ======================================================================
   // link domain: frame shifter
   logic frame_idle;
   logic [5:0] bit_count;
   logic [31:0] shift;
   logic [31:0] next_shift;
   logic [23:0] held_word;
   logic held_toggle;
   logic last_bit;
   logic [24:0] snap;

   // sync_b high ends the frame even if the link clock has stopped
   assign frame_idle = sync_b | ~rst_b;
   assign next_shift = {shift[30:0], serial_in};
   assign last_bit = frame_check ? (bit_count == 6'(FRAME_BITS_CHECKED - 1))
                                 : (bit_count == 6'(FRAME_BITS - 1));

   // bit counter, stops at 63 so extra clocks are ignored
   always_ff @(posedge link_clock or posedge frame_idle) begin
      if (frame_idle) begin
         bit_count <= 6'h00;
         shift <= 32'h00000000;
      end else begin
         shift <= next_shift;
         if (bit_count != 6'h3f) begin
            bit_count <= bit_count + 6'h01;
         end
      end
   end

   // a complete frame is held and announced by a toggle
   always_ff @(posedge link_clock or negedge rst_b) begin
      if (!rst_b) begin
         held_word <= 24'h000000;
         held_toggle <= 1'b0;
      end else if (last_bit) begin
         // check byte trails the word; it is stripped, not verified
         held_word <= frame_check ? next_shift[31:CHECK_BITS]
                                  : next_shift[23:0];
         held_toggle <= ~held_toggle;
      end
   end

   // status bits leave msb first in the low 16 bits of the 24-bit word; a check byte sends zeros
   always_ff @(posedge link_clock or posedge frame_idle) begin
      if (frame_idle) begin
         status_out <= 1'b0;
      end else if (snap[24] && bit_count < 6'(FRAME_BITS)) begin
         status_out <= snap[5'(FRAME_BITS - 1) - bit_count[4:0]];
      end else begin
         status_out <= 1'b0;
      end
   end

   // ======================================================================
   // crossings into the system domain
   logic [2:0] tog_sync;
   logic tog_seen;
   logic [2:0] sync_sync;
   logic [2:0] idle_sync;
   logic idle_stable;
   logic wr_ev;
   logic [23:0] cap_word;

   // three stages; a change counts once stages two and three agree
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         tog_sync <= 3'h0;
         sync_sync <= 3'h7;
         idle_sync <= 3'h0;
      end else begin
         tog_sync <= {tog_sync[1:0], held_toggle};
         sync_sync <= {sync_sync[1:0], sync_b};
         idle_sync <= {idle_sync[1:0], idle_level_pin};
      end
   end

   // frame event; the held word stays still until the next frame ends
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         tog_seen <= 1'b0;
         wr_ev <= 1'b0;
         cap_word <= 24'h000000;
      end else begin
         wr_ev <= 1'b0;
         if (tog_sync[1] == tog_sync[2] && tog_sync[2] != tog_seen) begin
            tog_seen <= tog_sync[2];
            wr_ev <= 1'b1;
            cap_word <= held_word;
         end
      end
   end

   // idle pin level filtered the same way
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         idle_stable <= 1'b0;
      end else if (idle_sync[1] == idle_sync[2]) begin
         idle_stable <= idle_sync[2];
      end
   end

   // ======================================================================
   // device address strap, caught once after reset release
   logic [1:0] dev_addr;
   logic strap_taken;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         dev_addr <= 2'h0;
         strap_taken <= 1'b0;
      end else if (!strap_taken) begin
         dev_addr <= device_select_pins;
         strap_taken <= 1'b1;
      end
   end

   // ======================================================================
   // decode
   logic is_write;
   qdc_target_e target;
   logic [1:0] chan;
   logic [15:0] data;
   logic sw_reset;
   logic kick;

   assign data = cap_word[15:0];
   assign chan = cap_word[POS_CHAN_HI -: 2];
   assign target = qdc_target_e'(cap_word[POS_TARGET_HI -: 3]);
   assign is_write = wr_ev && !cap_word[POS_RW]
      && cap_word[POS_DEV_HI -: 2] == dev_addr
      && cap_word[POS_GROUP_HI -: 3] == GROUP_CONTROL;
   assign sw_reset = is_write && target == QDC_TGT_SOFT
      && data[SW_CODE_BITS-1:0] == SW_RESET_CODE;
   assign kick = is_write && target == QDC_TGT_SOFT
      && data[SW_CODE_BITS-1:0] == SW_KICK_CODE;

   // ======================================================================
   // main control register
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         glob_cfg <= GLOB_RESET;
      end else if (sw_reset) begin
         glob_cfg <= GLOB_RESET;
      end else if (is_write && target == QDC_TGT_GLOBAL) begin
         glob_cfg.idle_output_level_invert <= data[GC_INVERT];
         glob_cfg.status_on_write_enable <= data[GC_STATUS];
         glob_cfg.watchdog_on <= data[GC_WD_ON];
         glob_cfg.watchdog_period_sel <= data[GC_WD_SEL_LO +: 2];
         glob_cfg.short_limit_select <= data[GC_SHORT];
         glob_cfg.global_output_on <= data[GC_OUT_ALL];
         glob_cfg.global_boost_power_up <= data[GC_BOOST_ALL];
      end
   end

   // per-channel control and slew registers, one slot per channel
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         chan_cfg <= {4{CHAN_RESET}};
         slew_cfg <= {4{SLEW_RESET}};
      end else if (sw_reset) begin
         chan_cfg <= {4{CHAN_RESET}};
         slew_cfg <= {4{SLEW_RESET}};
      end else if (is_write && target == QDC_TGT_CHANNEL) begin
         chan_cfg[chan].core_power_up <= data[CC_CORE];
         chan_cfg[chan].clear_participation <= data[CC_CLEAR];
         chan_cfg[chan].channel_output_on <= data[CC_OUT];
         chan_cfg[chan].sense_resistor_select <= data[CC_SENSE_RESISTOR_SELECT];
         chan_cfg[chan].channel_boost_power_up <= data[CC_BOOST];
         chan_cfg[chan].overrange_on <= data[CC_OVR];
         // code 110 is kept as written; only overrange_active reacts, its bit 2 blocking overrange as for any current range
         chan_cfg[chan].range_code <= data[CC_RANGE_LO +: 3];
      end else if (is_write && target == QDC_TGT_SLEW) begin
         slew_cfg[chan] <= data[SLEW_BITS-1:0];
      end
   end

   // boost converter register
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         boost_cfg <= BOOST_RESET;
      end else if (sw_reset) begin
         boost_cfg <= BOOST_RESET;
      end else if (is_write && target == QDC_TGT_BOOST) begin
         boost_cfg.boost_compensation_select <= data[BC_COMP];
         boost_cfg.boost_phase_select <= data[BC_PHASE_LO +: 2];
         // frequency code 11 is stored as is
         boost_cfg.boost_frequency_select <= data[BC_FREQ_LO +: 2];
         boost_cfg.boost_voltage_limit <= data[BC_VMAX_LO +: 2];
      end
   end

   // user toggle lands in the status word
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         status_word <= 16'h0000;
      end else if (sw_reset) begin
         status_word <= 16'h0000;
      end else if (is_write && target == QDC_TGT_SOFT) begin
         status_word[ST_TOGGLE] <= data[SW_TOGGLE];
      end
   end

   // snapshot for the link side, refreshed only between frames
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         snap <= 25'h0000000;
      end else if (sync_sync[1] && sync_sync[2]) begin
         snap <= {glob_cfg.status_on_write_enable, 8'h00, status_word};
      end
   end

   // ======================================================================
   // watchdog restarted by the kick code write or its own expiry, held at zero while off
   logic [31:0] wd_count;
   logic [31:0] wd_limit;
   logic wd_expire;

   // product stays well inside 32 bits for the documented periods
   always_comb begin
      case (glob_cfg.watchdog_period_sel)
         2'h0: wd_limit = 32'(WD_UNIT_CYCLES * WD_TIME_0_MS);
         2'h1: wd_limit = 32'(WD_UNIT_CYCLES * WD_TIME_1_MS);
         2'h2: wd_limit = 32'(WD_UNIT_CYCLES * WD_TIME_2_MS);
         2'h3: wd_limit = 32'(WD_UNIT_CYCLES * WD_TIME_3_MS);
         default: wd_limit = 32'(WD_UNIT_CYCLES * WD_TIME_0_MS);
      endcase
   end

   assign wd_expire = glob_cfg.watchdog_on && !kick
      && wd_count >= wd_limit - 32'h1;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         wd_count <= 32'h0;
      end else if (!glob_cfg.watchdog_on || kick || wd_expire) begin
         wd_count <= 32'h0;
      end else begin
         wd_count <= wd_count + 32'h1;
      end
   end

   // alert is sticky; an expiry in the kick cycle cannot occur
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         alert <= 1'b0;
      end else begin
         alert <= wd_expire | (alert & ~kick & ~sw_reset);
      end
   end

   // ======================================================================
   // derived per-channel state and idle level
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         output_active <= 4'h0;
         boost_active <= 4'h0;
         overrange_active <= 4'h0;
         idle_level <= 1'b0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            output_active[i] <= chan_cfg[i].channel_output_on
               | glob_cfg.global_output_on;
            boost_active[i] <= chan_cfg[i].channel_boost_power_up
               | glob_cfg.global_boost_power_up;
            // current ranges never get overrange
            overrange_active[i] <= chan_cfg[i].overrange_on
               & ~chan_cfg[i].range_code[CC_RANGE_CURRENT];
         end
         idle_level <= idle_stable ^ glob_cfg.idle_output_level_invert;
      end
   end

   // ======================================================================
   // checks
   sequence s_soft_write;
      is_write && target == QDC_TGT_SOFT;
   endsequence

   sequence s_reset_code;
      s_soft_write ##0 data[11:0] == 12'h555;
   endsequence

   a_soft_reset_all: assert property (@(posedge clock)
      disable iff (!rst_b) s_reset_code |=> glob_cfg == GLOB_RESET
         && boost_cfg == BOOST_RESET && chan_cfg == {4{CHAN_RESET}})
      else $error("software reset left a field off its default");

   a_user_toggle: assert property (@(posedge clock)
      disable iff (!rst_b) s_soft_write ##0 data[11:0] != 12'h555
         |=> status_word[11] == $past(data[12]))
      else $error("status toggle bit did not follow soft write");

   a_range_store: assert property (@(posedge clock)
      disable iff (!rst_b) is_write && target == QDC_TGT_CHANNEL
         |=> chan_cfg[$past(chan)].range_code == $past(data[2:0]))
      else $error("range code not stored in addressed channel");

   a_global_enable: assert property (@(posedge clock)
      disable iff (!rst_b) glob_cfg.global_output_on [*2]
         |-> output_active == 4'hf)
      else $error("global enable did not open all outputs");

   a_current_no_ovr: assert property (@(posedge clock)
      disable iff (!rst_b) chan_cfg[0].range_code[2] [*2]
         |-> !overrange_active[0])
      else $error("overrange active on current range");

   a_wd_off_quiet: assert property (@(posedge clock)
      disable iff (!rst_b) !glob_cfg.watchdog_on && !alert
         |=> !alert)
      else $error("alert rose with watchdog off");

   a_kick_restart: assert property (@(posedge clock)
      disable iff (!rst_b) kick
         |=> wd_count == 32'h0 && !alert)
      else $error("kick did not restart watchdog");

   // the registered level lags its inputs by one clock
   a_idle_level: assert property (@(posedge clock)
      disable iff (!rst_b) $stable(idle_stable)
         |=> idle_level == $past(idle_stable
            ^ glob_cfg.idle_output_level_invert))
      else $error("idle level does not match pin and invert");

   a_other_device: assert property (@(posedge clock)
      disable iff (!rst_b) wr_ev && cap_word[22:21] != dev_addr
         |=> $stable(glob_cfg) && $stable(boost_cfg) && $stable(chan_cfg))
      else $error("frame for another device changed the bank");

   a_boost_freq_keep: assert property (@(posedge clock)
      disable iff (!rst_b) is_write && target == QDC_TGT_BOOST
         |=> boost_cfg.boost_frequency_select == $past(data[3:2]))
      else $error("frequency code not stored as written");

endmodule // qdc_bank

// ### qdc_host_model.sv
`timescale 1ns/100ps

// ==========================================================================
// host side of the serial link: writes whole frames, captures status_out
module qdc_host_model (
   // serial link
   output logic link_clock,
   output logic sync_b,
   output logic serial_in,
   input wire logic status_out
);
   localparam realtime HALF = 62.5;

   // link clock stands still low between frames
   initial begin
      link_clock = 1'b0;
      sync_b = 1'b1;
      serial_in = 1'b0;
   end

   // one frame of nbits (24 or 32), msb first; data changes on the falling
   // link edge; a small skew keeps link edges off the system clock edges
   task automatic send(input logic [31:0] word, input int nbits,
      output logic [23:0] seen);
      #1.7;
      seen = '0;
      sync_b = 1'b0;
      for (int i = nbits - 1; i >= 0; i--) begin
         serial_in = word[i];
         #HALF link_clock = 1'b1;
         #HALF link_clock = 1'b0;
         seen = {seen[22:0], status_out};
      end
      #HALF sync_b = 1'b1;
      // released line shows the inverse so a stale bit never looks valid
      serial_in = ~word[0];
   endtask
endmodule // qdc_host_model

// ### tb_quad_dac_control_registers.sv
`timescale 1ns/100ps

module tb_quad_dac_control_registers;
   import qdc_pkg::*;
   localparam int UNIT = 4;
   typedef struct packed {
      logic [23:0] frame;
      logic [1:0] sel;
      logic [1:0] ch;
      logic [15:0] exp;
   } qdc_row_s;

   logic clock, rst_b, link_clock, sync_b, serial_in, status_out;
   logic frame_check;
   logic idle_level_pin, idle_level, alert;
   qdc_glob_s glob_cfg;
   qdc_chan_s [3:0] chan_cfg;
   qdc_boost_s boost_cfg;
   logic [3:0][12:0] slew_cfg;
   logic [3:0] output_active, boost_active, overrange_active;
   logic [15:0] status_word;
   logic [23:0] seen;
   int bad_count = 0;
   int total_checks = 0;
   int n, wt;
   int per [4] = '{5, 10, 100, 200};
   // frame, result select (glob, chan, boost, slew), channel, expected
   qdc_row_s rows [13] = '{
      {24'h1c3860, 2'd0, 2'd0, 16'h00c6}, {24'h9c2000, 2'd0, 2'd0, 16'h00c6},
      {24'h182000, 2'd0, 2'd0, 16'h00c6}, {24'h3c2000, 2'd0, 2'd0, 16'h00c6},
      {24'h1c2000, 2'd0, 2'd0, 16'h0000}, {24'h1c4106, 2'd1, 2'd0, 16'h0106},
      {24'h1d40c5, 2'd1, 2'd1, 16'h00c5}, {24'h1e403b, 2'd1, 2'd2, 16'h003b},
      {24'h1f40a8, 2'd1, 2'd3, 16'h00a8}, {24'h1c607f, 2'd2, 2'd0, 16'h007f},
      {24'h1c600c, 2'd2, 2'd0, 16'h000c}, {24'h1c6046, 2'd2, 2'd0, 16'h0046},
      {24'h1d1abc, 2'd3, 2'd1, 16'h1abc}};

   // ======================================================================
   // clock, design and host
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   qdc_bank #(.WD_UNIT_CYCLES(UNIT)) u_dut (.clock(clock), .rst_b(rst_b),
      .link_clock(link_clock), .sync_b(sync_b), .serial_in(serial_in),
      .frame_check(frame_check), .status_out(status_out),
      .device_select_pins(2'b00), .idle_level_pin(idle_level_pin),
      .glob_cfg(glob_cfg), .chan_cfg(chan_cfg), .boost_cfg(boost_cfg),
      .slew_cfg(slew_cfg), .output_active(output_active),
      .boost_active(boost_active), .overrange_active(overrange_active),
      .idle_level(idle_level), .status_word(status_word), .alert(alert));

   qdc_host_model u_host (.link_clock(link_clock), .sync_b(sync_b),
      .serial_in(serial_in), .status_out(status_out));

   // ======================================================================
   // helpers
   task automatic check_val(string what, logic [63:0] got, logic [63:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic check_cnt(string what, int got, int lo, int hi);
      total_checks++;
      if (got < lo || got > hi) begin
         bad_count++;
         $display("[FAIL] %0t %s count %0d not in %0d..%0d", $time, what,
            got, lo, hi);
      end
   endtask

   // settle time covers the crossing plus the derived-output stage
   task automatic put(logic [23:0] w);
      u_host.send({8'h00, w}, 24, seen);
      repeat (8) @(negedge clock);
   endtask

   function automatic logic [63:0] row_val(qdc_row_s r);
      case (r.sel)
         2'd0: return 64'(glob_cfg);
         2'd1: return 64'(chan_cfg[r.ch]);
         2'd2: return 64'(boost_cfg);
         default: return 64'(slew_cfg[r.ch]);
      endcase
   endfunction

   task automatic summarize;
      if (bad_count == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // hang guard well past the full run length
   initial begin
      #450000;
      bad_count++;
      summarize();
   end

   // ======================================================================
   // main sequence
   initial begin
      rst_b = 1'b0;
      idle_level_pin = 1'b1;
      frame_check = 1'b0;
      repeat (5) @(negedge clock);
      rst_b = 1'b1;
      repeat (2) @(negedge clock);
      check_val("boost rst", boost_cfg, 64'h04);
      check_val("glob rst", glob_cfg, 64'h0);
      check_val("alert rst", alert, 64'h0);
      foreach (rows[i]) begin
         put(rows[i].frame);
         check_val("row", row_val(rows[i]), rows[i].exp);
      end
      check_val("out", output_active, 64'h2);
      check_val("ovr", overrange_active, 64'hc);
      check_val("bst", boost_active, 64'h4);
      // global enables only once no channel output or converter is on
      put(24'h1d4000);
      put(24'h1e4000);
      put(24'h1c2030);
      check_val("out all", output_active, 64'hf);
      check_val("bst all", boost_active, 64'hf);
      put(24'h1c2010);
      check_val("out off", output_active, 64'h0);
      check_val("idle", idle_level, 64'h1);
      // outputs are off, so the converters may go down; readback goes on
      put(24'h1c3800);
      check_val("idle inv", idle_level, 64'h0);
      idle_level_pin = 1'b0;
      repeat (8) @(negedge clock);
      check_val("idle pin", idle_level, 64'h1);
      for (int t = 1; t >= 0; t--) begin
         put({8'h1c, 3'b100, 1'(t), 12'h000});
         put(24'h1c3800);
         check_val("stat", seen, {12'h0, 1'(t), 11'h0});
         check_val("word", status_word, {4'h0, 1'(t), 11'h0});
      end
      // watchdog off, kick, then on with each period
      for (int s = 0; s < 4; s++) begin
         put(24'h1c2000);
         put(24'h1c8195);
         check_val("kick", alert, 64'h0);
         fork
            u_host.send({8'h00, 8'h1c, 3'b001, 3'b001, 2'(s), 8'h00}, 24,
               seen);
            begin
               // count from the enable itself, not from the frame end
               wt = 0;
               while (glob_cfg.watchdog_on !== 1'b1 && wt < 1000) begin
                  @(negedge clock);
                  wt++;
               end
               n = 0;
               while (alert !== 1'b1 && n < 2000) begin
                  @(negedge clock);
                  n++;
               end
            end
         join
         check_cnt("wd", n, per[s] * UNIT - 1, per[s] * UNIT + 1);
         if (wt == 1000 || n == 2000) begin
            bad_count++;
            summarize();
         end
      end
      put(24'h1c8555);
      check_val("sr glob", glob_cfg, 64'h0);
      check_val("sr chan", chan_cfg, 64'h0);
      check_val("sr boost", boost_cfg, 64'h04);
      check_val("sr slew", slew_cfg, 64'h0);
      check_val("sr alert", alert, 64'h0);
      // checked frames: the trailing byte is dropped, the word still lands
      frame_check = 1'b1;
      u_host.send({24'h1c6046, 8'h5a}, 32, seen);
      repeat (8) @(negedge clock);
      check_val("chk frame", boost_cfg, 64'h46);
      summarize();
   end
endmodule // tb_quad_dac_control_registers
